//--- fad_map.svh
// Register offsets, field positions, codes and reset values of the channel.
`ifndef FAD_MAP_SVH
`define FAD_MAP_SVH
`define FAD_OFF_SRC      12'h000
`define FAD_OFF_DST      12'h004
`define FAD_OFF_TCNT     12'h008
`define FAD_OFF_BCNT     12'h00C
`define FAD_OFF_CTL1     12'h010
`define FAD_OFF_CTL2     12'h014
`define FAD_OFF_STAT     12'h018
`define FAD_C1_EN        7
`define FAD_C1_WORD      6
`define FAD_C1_SDIR      5
`define FAD_C1_SSTEP     4
`define FAD_C1_IRQEN     3
`define FAD_C2_MEN       7
`define FAD_C2_DDIR      6
`define FAD_C2_DSTEP     5
`define FAD_C2_AREA      4
`define FAD_ST_END       0
`define FAD_ST_BUSY      1
`define FAD_SEL_BLOCK    3'h7
`define FAD_SEL_EDGE     3'h4
`define FAD_SEL_LEVEL    3'h5
`define FAD_SEL_AUTO_CS  3'h6
`define FAD_SEL_AUTO_BU  3'h7
`define FAD_RST_CTL      8'h00
`define FAD_RST_ADDR     24'h00_0000
`define FAD_RST_CNT      16'h0000
`endif

//--- fad_pkg.sv
// Types shared by the channel and its testbench.
package fad_pkg;
   typedef enum logic [1:0] {FAD_IDLE, FAD_BUSREQ, FAD_READ, FAD_WRITE} fad_state_t;
   typedef struct packed {
      logic [23:0] addr;
      logic        rd;
      logic        wr;
      logic        word;
      logic [15:0] wdata;
   } fad_mem_req_t;
endpackage

//--- fad_req_sync.sv
// Synchroniser and falling-edge detector for the external request pin.
`timescale 1ns/10ps
`default_nettype none
module fad_req_sync
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_n,
   output logic      level_low,
   output logic      fall
);
   logic meta_r;
   logic sync_r;
   logic prev_r;

   // The idle level of the pin is high.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= 1'b1;
         sync_r <= 1'b1;
         prev_r <= 1'b1;
      end
      else
      begin
         meta_r <= pin_n;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_low = ~sync_r;
   assign fall      = prev_r & ~sync_r;
endmodule
`default_nettype wire

//--- fad_channel.sv
// Full-address DMA channel with normal and block transfer modes behind APB.
`timescale 1ns/10ps
`default_nettype none
`include "fad_map.svh"
//
// Contract
// - Normal mode moves one byte or word per request, for the programmed count.
// - Source and destination 24-bit addresses step up, down or stay, independently.
// - Normal mode decrements transfer count per unit; zero clears enable and stops.
// - End of normal sequence raises CPU interrupt when end interrupt is enabled.
// - A count loaded as zero means 65,536 transfers.
// - Normal mode takes external edge, external level or auto-request only.
// - Cycle-steal releases the bus after every unit.
// - Burst keeps the bus until done unless a higher master requests it.
// - Block mode request moves a whole block, stepping addresses and size counter.
// - Block-size counter at zero reloads from the untouched initial size.
// - Block area address returns to its start value after each block.
// - Block count decrements per block; zero ends, clears enable, may interrupt.
// - Block mode starts only from timer 0..3 compare or external edge.
// - Size bit picks byte or word; two bit pairs pick address stepping.
// - Serial and short-address sources are never accepted by this channel.
// - Selected timer interrupt is withheld from CPU and its flag cleared.
// - Level requests keep transferring while low, releasing bus per unit.
// - Transfer-end output is low during the final write of an edge-requested block or of an edge- or level-requested normal sequence;
//   timer-started blocks and auto-requests leave it high.
module fad_channel
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic                        bus_req,
   input  wire logic                   bus_gnt,
   input  wire logic                   bus_hp_req,
   output fad_pkg::fad_mem_req_t       mem_req,
   input  wire logic [15:0]            mem_rdata,
   input  wire logic                   mem_ack,
   input  wire logic [3:0]             timer_irq,
   output logic      [3:0]             cpu_timer_irq,
   output logic      [3:0]             irq_flag_clear,
   input  wire logic                   ext_transfer_request_n,
   output logic                        transfer_end_n,
   output logic                        end_irq
);
   fad_pkg::fad_state_t   state_r;
   fad_pkg::fad_mem_req_t mem_req_r;
   logic [7:0]  ctl1_r;
   logic [7:0]  ctl2_r;
   logic [23:0] src_r;
   logic [23:0] dst_r;
   logic [23:0] base_r;
   logic [15:0] tcnt_r;
   logic [15:0] bcnt_r;
   logic [15:0] tcnt_dec;
   logic [15:0] bcnt_dec;
   logic [7:0]  bsz_dec;
   logic [23:0] step;
   logic [31:0] prdata_r;
   logic [3:0]  cpu_irq_r;
   logic [3:0]  flag_clr_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        bus_req_r;
   logic        transfer_end_n_n_r;
   logic        end_flag_r;
   logic        end_flag_nxt;
   logic        end_irq_r;
   logic        pend_r;
   logic        blk_run_r;
   logic        level_low;
   logic        fall;
   logic        wr_en;
   logic        blk_mode;
   logic        active;
   logic        timer_sel;
   logic        evt;
   logic        level_req;
   logic        auto_req;
   logic        burst;
   logic        want;
   logic        start;
   logic        unit_done;
   logic        blk_end;
   logic        done;
   logic        keep;
   logic        last_unit;
   logic        ext_src;
   logic [2:0]  sel;

   fad_req_sync u_sync
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin_n     (ext_transfer_request_n),
      .level_low (level_low),
      .fall      (fall)
   );

   // Source decode.
   assign sel       = ctl2_r[2:0];
   assign blk_mode  = ctl1_r[2:0] == `FAD_SEL_BLOCK;
   assign active    = ctl1_r[`FAD_C1_EN] & ctl2_r[`FAD_C2_MEN];
   assign timer_sel = blk_mode & ~sel[2];
   // Timers only in block mode; serial and auto sources never start a block.
   assign evt = blk_mode ? ((timer_sel & timer_irq[sel[1:0]])
                            | (sel == `FAD_SEL_EDGE & fall))
                         : (sel == `FAD_SEL_EDGE & fall);
   assign level_req = ~blk_mode & sel == `FAD_SEL_LEVEL & level_low;
   assign auto_req  = ~blk_mode & (sel == `FAD_SEL_AUTO_CS | sel == `FAD_SEL_AUTO_BU);
   assign burst     = ~blk_mode & sel == `FAD_SEL_AUTO_BU;
   assign ext_src   = sel == `FAD_SEL_EDGE | (~blk_mode & sel == `FAD_SEL_LEVEL);
   assign want      = active & (pend_r | level_req | auto_req | blk_run_r);
   assign start     = state_r == fad_pkg::FAD_IDLE & want;

   // Per-unit arithmetic.
   assign step      = ctl1_r[`FAD_C1_WORD] ? 24'h00_0002 : 24'h00_0001;
   assign tcnt_dec  = tcnt_r - 16'h0001;
   assign bsz_dec   = tcnt_r[15:8] - 8'h01;
   assign bcnt_dec  = bcnt_r - 16'h0001;
   assign unit_done = state_r == fad_pkg::FAD_WRITE & mem_ack;
   assign blk_end   = unit_done & blk_mode & bsz_dec == 8'h00;
   assign done      = blk_mode ? blk_end & bcnt_dec == 16'h0000
                               : unit_done & tcnt_dec == 16'h0000;
   assign keep      = ~bus_hp_req & (blk_mode ? ~blk_end : burst & ~done);
   assign last_unit = blk_mode ? tcnt_r[15:8] == 8'h01 : tcnt_r == 16'h0001;
   assign wr_en     = psel & penable & pready_r & pwrite;

   // Transfer sequencer.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_r <= fad_pkg::FAD_IDLE;
      else
      begin
         unique case (state_r)
            fad_pkg::FAD_IDLE:   if (want) state_r <= fad_pkg::FAD_BUSREQ;
            fad_pkg::FAD_BUSREQ: if (bus_gnt) state_r <= fad_pkg::FAD_READ;
            fad_pkg::FAD_READ:   if (mem_ack) state_r <= fad_pkg::FAD_WRITE;
            fad_pkg::FAD_WRITE:
               if (mem_ack)
                  state_r <= keep ? fad_pkg::FAD_READ : fad_pkg::FAD_IDLE;
         endcase
      end
   end

   // Bus ownership, memory cycles and transfer-end strobe.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_req_r <= 1'b0;
         mem_req_r <= '0;
         transfer_end_n_n_r  <= 1'b1;
      end
      else
      begin
         if (start)
            bus_req_r <= 1'b1;
         else if (unit_done & ~keep)
            bus_req_r <= 1'b0;
         if ((state_r == fad_pkg::FAD_BUSREQ & bus_gnt) | (unit_done & keep))
         begin
            mem_req_r.addr <= unit_done ? src_nxt(src_r) : src_r;
            mem_req_r.rd   <= 1'b1;
            mem_req_r.wr   <= 1'b0;
            mem_req_r.word <= ctl1_r[`FAD_C1_WORD];
         end
         else if (state_r == fad_pkg::FAD_READ & mem_ack)
         begin
            mem_req_r.addr  <= dst_r;
            mem_req_r.rd    <= 1'b0;
            mem_req_r.wr    <= 1'b1;
            mem_req_r.wdata <= mem_rdata;
            transfer_end_n_n_r        <= ~(ext_src & last_unit);
         end
         else if (unit_done)
         begin
            mem_req_r.rd <= 1'b0;
            mem_req_r.wr <= 1'b0;
            transfer_end_n_n_r     <= 1'b1;
         end
      end
   end

   function automatic logic [23:0] src_nxt(input logic [23:0] a);
      if (!ctl1_r[`FAD_C1_SSTEP])
         src_nxt = a;
      else
         src_nxt = ctl1_r[`FAD_C1_SDIR] ? a - step : a + step;
   endfunction

   function automatic logic [23:0] dst_nxt(input logic [23:0] a);
      if (!ctl2_r[`FAD_C2_DSTEP])
         dst_nxt = a;
      else
         dst_nxt = ctl2_r[`FAD_C2_DDIR] ? a - step : a + step;
   endfunction

   // Request latch, block run flag and block area start address.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pend_r    <= 1'b0;
         blk_run_r <= 1'b0;
         base_r    <= `FAD_RST_ADDR;
      end
      else
      begin
         if (start)
            pend_r <= 1'b0;
         else if (active & state_r == fad_pkg::FAD_IDLE & ~blk_run_r & evt)
            pend_r <= 1'b1;
         if (start & blk_mode & ~blk_run_r)
         begin
            blk_run_r <= 1'b1;
            base_r    <= ctl2_r[`FAD_C2_AREA] ? src_r : dst_r;
         end
         else if (blk_end | ~active)
            blk_run_r <= 1'b0;
      end
   end

   // Address registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         src_r <= `FAD_RST_ADDR;
         dst_r <= `FAD_RST_ADDR;
      end
      else
      begin
         if (wr_en & paddr == `FAD_OFF_SRC)
            src_r <= pwdata[23:0];
         else if (blk_end & ctl2_r[`FAD_C2_AREA])
            src_r <= base_r;
         else if (unit_done)
            src_r <= src_nxt(src_r);
         if (wr_en & paddr == `FAD_OFF_DST)
            dst_r <= pwdata[23:0];
         else if (blk_end & ~ctl2_r[`FAD_C2_AREA])
            dst_r <= base_r;
         else if (unit_done)
            dst_r <= dst_nxt(dst_r);
      end
   end

   // Counters.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tcnt_r <= `FAD_RST_CNT;
         bcnt_r <= `FAD_RST_CNT;
      end
      else
      begin
         if (wr_en & paddr == `FAD_OFF_TCNT)
            tcnt_r <= pwdata[15:0];
         else if (blk_end)
            tcnt_r[15:8] <= tcnt_r[7:0];
         else if (unit_done & blk_mode)
            tcnt_r[15:8] <= bsz_dec;
         else if (unit_done)
            tcnt_r <= tcnt_dec;
         if (wr_en & paddr == `FAD_OFF_BCNT)
            bcnt_r <= pwdata[15:0];
         else if (blk_end)
            bcnt_r <= bcnt_dec;
      end
   end

   // Control registers; the channel enable drops when the sequence ends.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl1_r <= `FAD_RST_CTL;
         ctl2_r <= `FAD_RST_CTL;
      end
      else
      begin
         if (wr_en & paddr == `FAD_OFF_CTL1)
            ctl1_r <= pwdata[7:0];
         else if (done)
            ctl1_r[`FAD_C1_EN] <= 1'b0;
         if (wr_en & paddr == `FAD_OFF_CTL2)
            ctl2_r <= {pwdata[7:4], 1'b0, pwdata[2:0]};
      end
   end

   // End flag and interrupt; a new end wins over a clear.
   assign end_flag_nxt = done | (end_flag_r & ~(wr_en & paddr == `FAD_OFF_STAT
                                               & pwdata[`FAD_ST_END]));
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         end_flag_r <= 1'b0;
         end_irq_r  <= 1'b0;
      end
      else
      begin
         end_flag_r <= end_flag_nxt;
         end_irq_r  <= end_flag_nxt & ctl1_r[`FAD_C1_IRQEN];
      end
   end

   // Timer interrupt steering toward the CPU.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cpu_irq_r  <= 4'h0;
         flag_clr_r <= 4'h0;
      end
      else
      begin
         cpu_irq_r  <= timer_irq & ~({4{active & timer_sel}} & (4'h1 << sel[1:0]));
         flag_clr_r <= {4{start & timer_sel & pend_r}} & (4'h1 << sel[1:0]);
      end
   end

   // APB slave with one access cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end
      else
      begin
         pready_r  <= psel & ~penable;
         pslverr_r <= 1'b0;
         if (psel & ~penable)
         begin
            prdata_r <= 32'h0000_0000;
            unique case (paddr)
               `FAD_OFF_SRC:  prdata_r[23:0] <= src_r;
               `FAD_OFF_DST:  prdata_r[23:0] <= dst_r;
               `FAD_OFF_TCNT: prdata_r[15:0] <= tcnt_r;
               `FAD_OFF_BCNT: prdata_r[15:0] <= bcnt_r;
               `FAD_OFF_CTL1: prdata_r[7:0]  <= ctl1_r;
               `FAD_OFF_CTL2: prdata_r[7:0]  <= ctl2_r;
               `FAD_OFF_STAT: prdata_r[1:0]  <= {state_r != fad_pkg::FAD_IDLE, end_flag_r};
               default:       pslverr_r      <= 1'b1;
            endcase
         end
      end
   end

   assign prdata         = prdata_r;
   assign pready         = pready_r;
   assign pslverr        = pslverr_r;
   assign bus_req        = bus_req_r;
   assign mem_req        = mem_req_r;
   assign transfer_end_n = transfer_end_n_n_r;
   assign end_irq        = end_irq_r;
   assign cpu_timer_irq  = cpu_irq_r;
   assign irq_flag_clear = flag_clr_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_last_read;
      state_r == fad_pkg::FAD_READ && mem_ack && ext_src && last_unit;
   endsequence
   sequence s_end_write;
      !transfer_end_n && mem_req.wr;
   endsequence

   chk_count_step: assert property (unit_done && !blk_mode && !wr_en
      |=> tcnt_r == $past(tcnt_dec))
      else $error("transfer count did not step down");
   chk_enable_drop: assert property (done && !wr_en |=> !ctl1_r[`FAD_C1_EN] && !bus_req)
      else $error("enable not cleared at end");
   chk_end_irq: assert property (done && ctl1_r[`FAD_C1_IRQEN] && !wr_en |=> end_irq)
      else $error("end interrupt missing");
   chk_steal_release: assert property (unit_done && !blk_mode && !burst
      |=> state_r == fad_pkg::FAD_IDLE && !bus_req)
      else $error("bus not released after unit");
   chk_burst_hold: assert property (unit_done && burst && !done && !bus_hp_req
      |=> bus_req && mem_req.rd)
      else $error("burst lost the bus");
   chk_size_reload: assert property (blk_end && !wr_en |=> tcnt_r[15:8] == tcnt_r[7:0])
      else $error("block size not reloaded");
   chk_area_restore: assert property (blk_end && !wr_en && !ctl2_r[`FAD_C2_AREA]
      |=> dst_r == $past(base_r))
      else $error("block area not restored");
   chk_block_count: assert property (blk_end && !wr_en
      |=> bcnt_r == $past(bcnt_r) - 16'h0001)
      else $error("block count not stepped");
   chk_transfer_end_n_final: assert property (s_last_read |=> s_end_write)
      else $error("transfer end not driven on last write");
   chk_timer_mask: assert property (active && timer_sel
      |=> cpu_timer_irq[$past(sel[1:0])] == 1'b0)
      else $error("selected timer reached the cpu");
   chk_normal_timer: assert property (!blk_mode && !pend_r && !fall |=> !pend_r)
      else $error("timer accepted in normal mode");
endmodule
`default_nettype wire

//--- fad_bus_model.sv
// Behavioural system bus controller and memory facing the channel.
`timescale 1ns/10ps
`default_nettype none
module fad_bus_model
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  bus_req,
   output logic                       bus_gnt,
   input  wire fad_pkg::fad_mem_req_t mem_req,
   output logic      [15:0]           mem_rdata,
   output logic                       mem_ack,
   input  wire logic                  slow,
   output int                         wr_cnt,
   output int                         req_rise,
   output logic      [23:0]           wr_addr,
   output logic      [15:0]           wr_data
);
   logic       req_r;
   logic [1:0] wait_r;

   // Grants the bus a cycle after each request, answers reads and writes promptly or slowly.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bus_gnt   <= 1'b0;
         req_r     <= 1'b0;
         mem_ack   <= 1'b0;
         mem_rdata <= 16'h0000;
         wait_r    <= 2'h0;
         wr_cnt    <= 0;
         req_rise  <= 0;
         wr_addr   <= 24'h00_0000;
         wr_data   <= 16'h0000;
      end
      else
      begin
         bus_gnt   <= bus_req;
         req_r     <= bus_req;
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;
         if (bus_req && !req_r)
            req_rise <= req_rise + 1;
         if (mem_ack && mem_req.wr)
         begin
            wr_cnt  <= wr_cnt + 1;
            wr_addr <= mem_req.addr;
            wr_data <= mem_req.wdata;
         end
         if ((mem_req.rd || mem_req.wr) && !mem_ack)
         begin
            if (wait_r != 2'h0)
               wait_r <= wait_r - 2'h1;
            else
            begin
               mem_ack <= 1'b1;
               wait_r  <= slow ? 2'h3 : 2'h0;
               if (mem_req.rd)
                  mem_rdata <= {mem_req.addr[7:0], ~mem_req.addr[7:0]};
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- full_address_dma_channel_bench.sv
// Self-checking testbench of the full-address DMA channel.
`timescale 1ns/10ps
`default_nettype none
`include "fad_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module full_address_dma_channel_bench;
   logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                  bus_req, bus_gnt, mem_ack, pin_n, transfer_end_n_n, end_irq, slow;
   logic [11:0]           paddr;
   logic [31:0]           pwdata, prdata, rdv;
   logic [15:0]           mem_rdata;
   logic [3:0]            timer_irq, cpu_irq, flag_clr;
   logic [23:0]           s, d, wa;
   logic [15:0]           wd;
   logic [2:0]            sels [4];
   logic                  w, hp;
   int                    error_cnt, n_checks, cyc, w0, r0, fc0, mask0, pass1, sz, tl;
   int                    wr_n, rise_n;
   fad_pkg::fad_mem_req_t mem_req;

   fad_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_req(bus_req), .bus_gnt(bus_gnt), .bus_hp_req(hp),
      .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .timer_irq(timer_irq),
      .cpu_timer_irq(cpu_irq), .irq_flag_clear(flag_clr), .ext_transfer_request_n(pin_n),
      .transfer_end_n(transfer_end_n_n), .end_irq(end_irq));
   fad_bus_model i_bus (.pclk(pclk), .presetn(presetn), .bus_req(bus_req), .bus_gnt(bus_gnt),
      .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .slow(slow),
      .wr_cnt(wr_n), .req_rise(rise_n), .wr_addr(wa), .wr_data(wd));

   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // Counts flag clears and timer interrupts passed on to the processor; cuts a hang short.
   always @(posedge pclk)
   begin
      cyc++;
      fc0   += flag_clr[0];
      mask0 += cpu_irq[0];
      pass1 += cpu_irq[1];
      tl    += (mem_ack && mem_req.wr && !transfer_end_n_n);
      if (cyc == 20000)
      begin
         error_cnt++;
         results();
      end
   end

   task automatic results();
      if (error_cnt == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv     = pslverr ? 32'hDEAD_BEEF : prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Configures with both enables clear, then sets master and channel enable after reading.
   task automatic setup(input logic [15:0] tc, bc, input logic [7:0] c1, c2);
      apb(1'b1, `FAD_OFF_SRC, {8'h00, s});
      apb(1'b1, `FAD_OFF_DST, {8'h00, d});
      apb(1'b1, `FAD_OFF_TCNT, {16'h0000, tc});
      apb(1'b1, `FAD_OFF_BCNT, {16'h0000, bc});
      apb(1'b1, `FAD_OFF_CTL2, {24'h00_0000, c2});
      apb(1'b1, `FAD_OFF_CTL1, {24'h00_0000, c1});
      apb(1'b0, `FAD_OFF_CTL2, 32'h0000_0000);
      apb(1'b1, `FAD_OFF_CTL2, {24'h00_0000, c2 | 8'h80});
      apb(1'b0, `FAD_OFF_CTL1, 32'h0000_0000);
      apb(1'b1, `FAD_OFF_CTL1, {24'h00_0000, c1 | 8'h80});
   endtask

   task automatic wait_wr(input int n);
      while (wr_n < n) @(posedge pclk);
      repeat (8) @(posedge pclk);
   endtask

   task automatic tpulse(input logic [3:0] b);
      @(posedge pclk);
      timer_irq <= b;
      @(posedge pclk);
      timer_irq <= 4'h0;
   endtask

   function automatic logic [15:0] mem_val(input logic [23:0] a);
      return {a[7:0], ~a[7:0]};
   endfunction

   initial
   begin
      {psel, penable, pwrite, slow, hp} = 5'h00;
      {paddr, pwdata, timer_irq} = 48'h0;
      pin_n = 1'b1;
      presetn = 1'b0;
      sels = '{3'h5, 3'h6, 3'h7, 3'h7};
      void'($urandom(69065));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 8; a++)
      begin
         apb(1'b0, 12'(4 * a), 32'h0000_0000);
         `CHK("reset or unmapped", (a == 7) ? 32'hDEAD_BEEF : 32'h0000_0000, rdv)
      end
      foreach (sels[i])
      begin
         s = 24'($urandom) & 24'hFF_FFFE;
         d = 24'($urandom) & 24'hFF_FFFE;
         w = 1'($urandom);
         sz = w ? 2 : 1;
         slow <= 1'($urandom);
         pin_n <= (sels[i] != 3'h5);
         hp <= (i == 3);
         r0 = rise_n;
         tl = 0;
         setup(16'h0003, 16'h0000, {1'b0, w, 6'h18}, {3'h3, 2'h0, sels[i]});
         wait_wr(wr_n + 3);
         pin_n <= 1'b1;
         hp <= 1'b0;
         `CHK("bus_grabs", (sels[i] == 3'h7 && i != 3) ? 1 : 3, rise_n - r0)
         `CHK("transfer_end_n_writes", (sels[i] == 3'h5) ? 1 : 0, tl)
         `CHK("end_irq", 1'b1, end_irq)
         `CHK("last_wr_addr", d - 24'(2 * sz), wa)
         if (w)
            `CHK("last_wr_data", mem_val(s + 24'(2 * sz)), wd)
         apb(1'b0, `FAD_OFF_SRC, 32'h0000_0000);
         `CHK("src", s + 24'(3 * sz), rdv[23:0])
         apb(1'b0, `FAD_OFF_DST, 32'h0000_0000);
         `CHK("dst", d - 24'(3 * sz), rdv[23:0])
         apb(1'b0, `FAD_OFF_TCNT, 32'h0000_0000);
         `CHK("count", 16'h0000, rdv[15:0])
         apb(1'b0, `FAD_OFF_CTL1, 32'h0000_0000);
         `CHK("enable", 1'b0, rdv[`FAD_C1_EN])
         apb(1'b1, `FAD_OFF_STAT, 32'h0000_0001);
      end
      w0 = wr_n;
      setup(16'h0000, 16'h0000, 8'h00, {5'h00, `FAD_SEL_EDGE});
      tpulse(4'h1);
      repeat (20) @(posedge pclk);
      `CHK("timer_refused", w0, wr_n)
      pin_n <= 1'b0;
      wait_wr(w0 + 1);
      pin_n <= 1'b1;
      apb(1'b0, `FAD_OFF_TCNT, 32'h0000_0000);
      `CHK("zero_count", 16'hFFFF, rdv[15:0])
      apb(1'b1, `FAD_OFF_CTL1, 32'h0000_0000);
      s = 24'($urandom) & 24'hFF_FFFE;
      d = 24'($urandom) & 24'hFF_FFFE;
      w0 = wr_n;
      setup(16'h0202, 16'h0002, {2'h1, 6'h1F}, 8'h20);
      fc0 = 0;
      mask0 = 0;
      pass1 = 0;
      tpulse(4'h3);
      tpulse(4'h1);
      wait_wr(w0 + 2);
      `CHK("one_block", w0 + 2, wr_n)
      apb(1'b0, `FAD_OFF_BCNT, 32'h0000_0000);
      `CHK("blocks_left", 16'h0001, rdv[15:0])
      apb(1'b0, `FAD_OFF_DST, 32'h0000_0000);
      `CHK("area_restore", d, rdv[23:0])
      apb(1'b0, `FAD_OFF_TCNT, 32'h0000_0000);
      `CHK("size_reload", 16'h0202, rdv[15:0])
      tpulse(4'h1);
      wait_wr(w0 + 4);
      apb(1'b0, `FAD_OFF_SRC, 32'h0000_0000);
      `CHK("block_src", s + 24'h00_0008, rdv[23:0])
      apb(1'b0, `FAD_OFF_CTL1, 32'h0000_0000);
      `CHK("block_enable", 1'b0, rdv[`FAD_C1_EN])
      `CHK("block_irq", 1'b1, end_irq)
      `CHK("block_wr", mem_val(s + 24'h00_0006), wd)
      `CHK("block_wr_addr", d + 24'h00_0002, wa)
      `CHK("flag_clears", 2, fc0)
      `CHK("masked_irq", 0, mask0)
      `CHK("passed_irq", 1, pass1)
      results();
   end
endmodule
`default_nettype wire
